// file: design/crsm_regs.vh
`ifndef CRSM_REGS_VH
`define CRSM_REGS_VH
// apb register byte offsets
`define CRSM_OFF_CTRL 12'h000
`define CRSM_OFF_SENSE 12'h004
`define CRSM_OFF_STAT 12'h008
`define CRSM_OFF_CMD 12'h00C
// ctrl fields
`define CRSM_CTRL_F51 0
`define CRSM_CTRL_F66 1
`define CRSM_CTRL_RESET 32'h0000_0000
// sense byte zero bit positions
`define CRSM_SB0_CMDREJ 0
`define CRSM_SB0_INTREQ 1
`define CRSM_SB0_BUSOUT 2
`define CRSM_SB0_EQCHK 3
`define CRSM_SB0_DATCHK 4
`define CRSM_SB0_OVRUN 5
`define CRSM_SB0_STOP 6
`define CRSM_SB0_DEVCHK 7
// sense byte one bit positions
`define CRSM_SB1_COL0 0
`define CRSM_SB1_VALID 1
`define CRSM_SB1_COMP 2
`define CRSM_SB1_RESYNC 3
`define CRSM_SB1_XFER 4
`define CRSM_SB1_NA 5
`define CRSM_SB1_F51 6
`define CRSM_SB1_F66 7
// status byte positions
`define CRSM_ST_ATTN 0
`define CRSM_ST_DEVEND 5
`define CRSM_ST_UCHK 6
// command decode
`define CRSM_CMD_READ_MASK 8'h03
`define CRSM_CMD_READ_VAL 8'h02
`define CRSM_CMD_SENSE_MASK 8'h0F
`define CRSM_CMD_SENSE_VAL 8'h04
`define CRSM_CMD_FBIT 2
// timing, in milliseconds, and clock rate in khz
`define CRSM_CLK_KHZ 25000
`define CRSM_SPIN_MS 3000
`define CRSM_IDLE_MS 15000
`define CRSM_SPIN_CYC (`CRSM_SPIN_MS * `CRSM_CLK_KHZ)
`define CRSM_IDLE_CYC (`CRSM_IDLE_MS * `CRSM_CLK_KHZ)
`define CRSM_GATE_CYC 1000000
`endif

// file: design/crsm_top.v
// What this block does
// RULE1: undefined command sets command reject and unit check, stays idle.
// RULE2: operator-action condition sets intervention required.
// RULE3: bus-out-check position always reads zero.
// RULE4: read cells stuck or gate card late: equipment check, motors off, stop.
// RULE5: data check set when any sense byte one data error is set.
// RULE6: data overrun to channel sets overrun bit.
// RULE7: stop-state bit follows the stopped reader.
// RULE8: interlock sets device check and ends a running command at once.
// RULE9: column-zero error if any amplifier on at mid leading edge point.
// RULE10: translate mode: several punches in rows 1..7 gives validity error.
// RULE11: station one and two column data differ: compare error.
// RULE12: resync on hole edge, then hole must stay centred or resync error.
// RULE13: unordered card sensed: transfer check, motors off, status held to next start.
// RULE14: unused bit zero; feature bits show installed short-card options.
// RULE15: motors off while no cards are processed.
// RULE16: feed order starts spin-up delay that holds the feed actuator off.
// RULE17: feed order restarts idle timer; expiry turns motors off.
// RULE18: stop state turns motors off after idle delay; hard checks cut at once.
// RULE19: program feed starts when a read command is accepted.
// RULE20: abnormal condition halts reader, lights indicator, sets sense bits; code halts only on stop switch, equipment, transfer and interlock checks.
// RULE21: unit check set when any sense byte bit is set; code leaves out sense byte one bits 7..5 (feature bits and unused bit).
// RULE22: non-sense command after unit check clears command reject.
// RULE23: stop conditions persist for sense; other commands get unit check.
// RULE24: sense command sends both sense bytes then device end.
// RULE25: gate photocell transit limit is a parameter.
`include "crsm_regs.vh"
module crsm_top #(
  parameter SPIN_CYC = `CRSM_SPIN_CYC,
  parameter IDLE_CYC = `CRSM_IDLE_CYC,
  parameter GATE_CYC = `CRSM_GATE_CYC
) (
  input wire core_clk,
  input wire sys_rst,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire cmd_valid,
  input wire [7:0] cmd_code,
  output reg cmd_ack,
  output reg status_valid,
  output reg [7:0] status_byte,
  input wire status_accept,
  output reg sense_valid,
  output reg [7:0] sense_data,
  input wire sense_accept,
  input wire overrun_det,
  input wire read_cells_pin,
  input wire gate_cell_pin,
  input wire card_path_pin,
  input wire interlock_pin,
  input wire stop_sw_pin,
  input wire run_sw_pin,
  input wire feed_sw_pin,
  input wire hopper_empty_pin,
  input wire mid_edge_pin,
  input wire [11:0] amp_pin,
  input wire col_strobe_pin,
  input wire [11:0] st2_pin,
  input wire hole_edge_pin,
  input wire hole_check_pin,
  output reg motor_on,
  output reg feed_coil,
  output reg [7:0] panel_ind,
  output reg reader_busy
);
  // one-hot sequencer states
  localparam S_IDLE = 4'b0001;
  localparam S_READ = 4'b0010;
  localparam S_SNS0 = 4'b0100;
  localparam S_SNS1 = 4'b1000;
  // pin synchronisers, first stage only feeds second
  reg [35:0] sync1;
  reg [35:0] sync2;
  always @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      sync1 <= 36'h0_0000_0000;
      sync2 <= 36'h0_0000_0000;
    end else begin
      sync1 <= {read_cells_pin, gate_cell_pin, card_path_pin, interlock_pin, stop_sw_pin,
                run_sw_pin, feed_sw_pin, hopper_empty_pin, mid_edge_pin, amp_pin,
                col_strobe_pin, st2_pin, hole_edge_pin, hole_check_pin};
      sync2 <= sync1;
    end
  end
  // synchronised pin views, in the order packed above
  wire s_read = sync2[35];
  wire s_gate = sync2[34];
  wire s_path = sync2[33];
  wire s_ilk = sync2[32];
  wire s_stop = sync2[31];
  wire s_run = sync2[30];
  wire s_feed = sync2[29];
  wire s_hop = sync2[28];
  wire s_mid = sync2[27];
  wire [11:0] s_amp = sync2[26:15];
  wire s_strb = sync2[14];
  wire [11:0] s_st2 = sync2[13:2];
  wire s_hedge = sync2[1];
  wire s_hchk = sync2[0];
  // working registers
  reg [7:0] prev;
  reg [31:0] ctrl;
  reg [3:0] state;
  reg [7:0] cur_cmd;
  reg stopped;
  // sticky sense flags and sequencing state
  reg cmd_rej, eq_chk, dev_chk, ovr, col0, valid_e, comp_e, resync_e, xfer_e;
  reg feed_ordered, hold_status, hard_cut, resync_pend;
  reg [31:0] spin_cnt, idle_cnt, gate_cnt, read_cnt;
  reg stop_seen;
  // edge detectors on synchronised pins
  wire feed_edge = s_feed & ~prev[0];
  wire strb_edge = s_strb & ~prev[1];
  wire mid_edge = s_mid & ~prev[2];
  wire hedge = s_hedge & ~prev[3];
  wire path_rise = s_path & ~prev[4];
  wire run_edge = s_run & ~prev[5];
  // command decode and intake qualifier
  wire is_sense = (cmd_code & `CRSM_CMD_SENSE_MASK) == `CRSM_CMD_SENSE_VAL;
  wire is_read = (cmd_code & `CRSM_CMD_READ_MASK) == `CRSM_CMD_READ_VAL;
  wire take = cmd_valid & (state == S_IDLE) & ~status_valid;
  wire intreq = s_hop;
  // hard fault set conditions, also shield their flags from a same-cycle clear
  wire eq_set = (s_gate && gate_cnt >= GATE_CYC) || (s_read && read_cnt >= GATE_CYC);
  wire xfer_set = path_rise & ~feed_ordered;
  // assembled sense bytes
  wire [7:0] sb1;
  wire [7:0] sb0;
  wire [6:0] punches = st2_rows(s_st2);
  // RULE14 feature bits
  assign sb1 = {ctrl[`CRSM_CTRL_F66], ctrl[`CRSM_CTRL_F51], 1'b0, xfer_e, resync_e,
                comp_e, valid_e, col0};
  // RULE3 RULE5 RULE2 sense byte zero
  assign sb0 = {dev_chk, stopped, ovr, col0 | valid_e | comp_e | resync_e, eq_chk, 1'b0,
                intreq, cmd_rej};
  // rows one to seven of a column
  function [6:0] st2_rows;
    input [11:0] c;
    begin
      st2_rows = c[9:3];
    end
  endfunction
  // RULE10 multi-punch test
  wire multi = (punches & (punches - 7'h01)) != 7'h00;
  // apb slave, zero wait
  always @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      ctrl <= `CRSM_CTRL_RESET;
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel & ~penable;
      pslverr <= 1'b0;
      if (psel & ~penable) begin
        case (paddr)
          `CRSM_OFF_CTRL: prdata <= ctrl;
          `CRSM_OFF_SENSE: prdata <= {16'h0000, sb1, sb0};
          `CRSM_OFF_STAT: prdata <= {16'h0000, state, stopped, motor_on, feed_coil,
                                    reader_busy, status_byte};
          `CRSM_OFF_CMD: prdata <= {24'h000000, cur_cmd};
          default: begin
            prdata <= 32'h0000_0000;
            pslverr <= 1'b1;
          end
        endcase
      end
      // write lands at the access edge, when pready is seen high
      if (psel & penable & pready & pwrite && paddr == `CRSM_OFF_CTRL)
        ctrl <= {30'h0, pwdata[1:0]};
    end
  end
  // command, sense and error flow
  always @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      prev <= 8'h00;
      state <= S_IDLE;
      cur_cmd <= 8'h00;
      stopped <= 1'b1;
      {cmd_rej, eq_chk, dev_chk, ovr, col0, valid_e, comp_e, resync_e, xfer_e} <= 9'h000;
      {feed_ordered, hold_status, hard_cut, resync_pend} <= 4'h0;
      gate_cnt <= 32'h0000_0000;
      read_cnt <= 32'h0000_0000;
      cmd_ack <= 1'b0;
      status_valid <= 1'b0;
      status_byte <= 8'h00;
      sense_valid <= 1'b0;
      sense_data <= 8'h00;
      reader_busy <= 1'b0;
      panel_ind <= 8'h00;
    end else begin
      prev <= {2'b00, s_run, s_path, s_hedge, s_mid, s_strb, s_feed};
      cmd_ack <= 1'b0;
      hard_cut <= 1'b0;
      reader_busy <= state != S_IDLE;
      // RULE20 panel indicators
      panel_ind <= {dev_chk, valid_e, xfer_e, s_hop, eq_chk | comp_e, stopped, ~stopped, 1'b0};
      if (status_valid & status_accept)
        status_valid <= 1'b0;
      // RULE7 operator stop and run
      if (s_stop)
        stopped <= 1'b1;
      else if (run_edge & ~eq_chk & ~dev_chk & ~xfer_e) begin
        stopped <= 1'b0;
        status_valid <= 1'b1;
        status_byte <= 8'h01 << `CRSM_ST_ATTN;
      end
      // RULE6 overrun
      if (overrun_det & state == S_READ)
        ovr <= 1'b1;
      // RULE4 gate photocell timer
      if (s_gate)
        gate_cnt <= gate_cnt + 32'h0000_0001;
      else
        gate_cnt <= 32'h0000_0000;
      // RULE25 limit from parameter
      if (eq_set) begin
        eq_chk <= 1'b1;
        stopped <= 1'b1;
        hard_cut <= 1'b1;
      end
      if (s_read)
        read_cnt <= read_cnt + 32'h0000_0001;
      else
        read_cnt <= 32'h0000_0000;
      // RULE13 card without a feed
      if (xfer_set) begin
        xfer_e <= 1'b1;
        stopped <= 1'b1;
        hard_cut <= 1'b1;
        hold_status <= 1'b1;
      end
      // RULE8 interlock
      if (s_ilk) begin
        dev_chk <= 1'b1;
        stopped <= 1'b1;
        hard_cut <= 1'b1;
        if (state == S_READ) begin
          state <= S_IDLE;
          status_valid <= 1'b1;
          status_byte <= (8'h01 << `CRSM_ST_DEVEND) | (8'h01 << `CRSM_ST_UCHK);
        end
      end
      // read card checks
      if (state == S_READ) begin
        // RULE9 column zero
        if (mid_edge && s_amp != 12'h000)
          col0 <= 1'b1;
        // RULE10 validity
        if (strb_edge && ~cur_cmd[`CRSM_CMD_FBIT] && multi)
          valid_e <= 1'b1;
        // RULE11 compare
        if (strb_edge && ~cur_cmd[6] && s_amp != s_st2)
          comp_e <= 1'b1;
        // RULE12 resync then verify
        if (hedge)
          resync_pend <= 1'b1;
        else if (strb_edge & resync_pend) begin
          resync_pend <= 1'b0;
          if (~s_hchk)
            resync_e <= 1'b1;
        end
        // end of card: read cells clear and card path just cleared
        if (~s_read & prev[4] & ~s_path) begin
          feed_ordered <= 1'b0;
          state <= S_IDLE;
          status_valid <= 1'b1;
          // RULE21 unit check when any sense byte zero bit or sense byte one bit 4..0 set
          status_byte <= (8'h01 << `CRSM_ST_DEVEND) |
                         ({7'h00, (|sb0) | (|sb1[4:0])} << `CRSM_ST_UCHK);
        end
      end
      if (feed_edge & ~stopped)
        feed_ordered <= 1'b1;
      // command intake
      if (take) begin
        cmd_ack <= 1'b1;
        cur_cmd <= cmd_code;
        hold_status <= 1'b0;
        if (is_sense) begin
          // RULE24 sense path
          state <= S_SNS0;
          sense_valid <= 1'b1;
          sense_data <= sb0;
        end else begin
          // RULE22 clear reject
          cmd_rej <= 1'b0;
          if (!is_read) begin
            // RULE1 reject
            cmd_rej <= 1'b1;
            status_valid <= 1'b1;
            status_byte <= 8'h01 << `CRSM_ST_UCHK;
          end else if (stopped) begin
            // RULE23 stop state refuses
            status_valid <= 1'b1;
            status_byte <= 8'h01 << `CRSM_ST_UCHK;
          end else begin
            // RULE19 program feed
            state <= S_READ;
            feed_ordered <= 1'b1;
            {col0, valid_e, comp_e, resync_e, ovr} <= 5'h00;
          end
        end
      end
      // RULE24 two sense bytes then device end
      case (state)
        S_SNS0: if (sense_accept) begin
          sense_data <= sb1;
          state <= S_SNS1;
        end
        S_SNS1: if (sense_accept) begin
          sense_valid <= 1'b0;
          state <= S_IDLE;
          status_valid <= 1'b1;
          status_byte <= 8'h01 << `CRSM_ST_DEVEND;
          if (~stopped & ~eq_set & ~xfer_set & ~s_ilk)
            {eq_chk, dev_chk, xfer_e} <= 3'h0;
        end
        S_IDLE, S_READ: ;
        default: state <= S_IDLE;
      endcase
      // RULE13 withhold status
      if (hold_status & ~take)
        status_valid <= 1'b0;
    end
  end
  // RULE21 unit check summary is folded into status byte above
  // motor sequencing
  always @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      motor_on <= 1'b0;
      feed_coil <= 1'b0;
      spin_cnt <= 32'h0000_0000;
      idle_cnt <= 32'h0000_0000;
      stop_seen <= 1'b1;
    end else begin
      stop_seen <= stopped;
      // RULE16 RULE17 feed order restarts both timers
      if ((feed_edge & ~stopped) | (take & is_read & ~is_sense & ~stopped)) begin
        motor_on <= 1'b1;
        spin_cnt <= SPIN_CYC;
        idle_cnt <= IDLE_CYC;
        feed_coil <= 1'b0;
      end else begin
        if (spin_cnt != 32'h0000_0000)
          spin_cnt <= spin_cnt - 32'h0000_0001;
        // RULE16 actuator held during spin-up
        feed_coil <= motor_on & (idle_cnt != 32'h0000_0000) & (spin_cnt == 32'h0000_0000) &
                     feed_ordered & ~stopped;
        // RULE15 RULE17 RULE18 idle shutdown
        if (idle_cnt != 32'h0000_0000)
          idle_cnt <= idle_cnt - 32'h0000_0001;
        else
          motor_on <= 1'b0;
      end
      // RULE18 soft stop entry restarts the idle delay
      if (stopped & ~stop_seen & motor_on)
        idle_cnt <= IDLE_CYC;
      // RULE4 RULE18 hard checks cut at once
      if (hard_cut) begin
        motor_on <= 1'b0;
        feed_coil <= 1'b0;
        idle_cnt <= 32'h0000_0000;
      end
    end
  end
endmodule // crsm_top

// file: tb/crsm_top_asserts.sv
module crsm_top_chk #(
  parameter SPIN_CYC = 50,
  parameter IDLE_CYC = 200
) (
  input wire core_clk,
  input wire sys_rst,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] prdata,
  input wire pready,
  input wire cmd_valid,
  input wire [7:0] cmd_code,
  input wire cmd_ack,
  input wire status_valid,
  input wire [7:0] status_byte,
  input wire status_accept,
  input wire sense_valid,
  input wire interlock_pin,
  input wire feed_sw_pin,
  input wire stop_sw_pin,
  input wire motor_on,
  input wire feed_coil,
  input wire reader_busy
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  int unsigned idle_n;
  int unsigned on_n;
  // motor run time and time since last feed order
  always @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      idle_n <= 0;
      on_n <= 0;
    end else begin
      on_n <= motor_on ? on_n + 1 : 0;
      idle_n <= (!motor_on || cmd_ack || feed_sw_pin || stop_sw_pin || reader_busy) ? 0 :
                idle_n + 1;
    end
  end
  AST_APB_ANS: assert property (psel && !penable |=> pready)
    else $error("apb setup not answered");
  AST_SB_ZERO: assert property (psel && penable && pready && !pwrite && paddr == 12'h004
    |-> !prdata[2] && !prdata[13]) else $error("unused sense bit set");
  AST_REJECT: assert property (cmd_valid && !reader_busy && !status_valid && !sense_valid
    && cmd_code[1:0] != 2'b10 && cmd_code[3:0] != 4'h4 |=> status_valid && status_byte[6])
    else $error("bad command not rejected");
  AST_SENSE_END: assert property ($fell(sense_valid)
    |-> status_valid && status_byte[5] && !status_byte[6]) else $error("sense end status wrong");
  AST_STAT_HOLD: assert property (status_valid && !status_accept
    |=> status_valid && $stable(status_byte)) else $error("status dropped early");
  AST_SPIN: assert property (feed_coil |-> motor_on && on_n >= SPIN_CYC - 4)
    else $error("feed coil before spin up");
  AST_INTLK_OFF: assert property (interlock_pin [*5] |-> !motor_on)
    else $error("motor on under interlock");
  AST_IDLE_OFF: assert property (idle_n <= IDLE_CYC + 8)
    else $error("motor idle too long");
endmodule // crsm_top_chk

// file: tb/crsm_host.sv
module crsm_host (
  input wire core_clk,
  input wire cmd_ack,
  input wire status_valid,
  input wire sense_valid,
  input wire [7:0] status_byte,
  input wire [7:0] sense_data,
  output logic cmd_valid,
  output logic status_accept,
  output logic sense_accept,
  output logic [7:0] cmd_code
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    cmd_valid = 0;
    status_accept = 0;
    sense_accept = 0;
    cmd_code = 0;
  end
  // one command: drain old status, send, take sense bytes and status
  task automatic issue(input logic [7:0] code, input int lag,
      output logic [7:0] st, output logic [15:0] sb);
    sb = 16'h0000;
    if (status_valid) begin
      status_accept <= 1;
      @(posedge core_clk);
      status_accept <= 0;
      @(posedge core_clk);
    end
    cmd_code <= code;
    cmd_valid <= 1;
    do @(posedge core_clk); while (!cmd_ack && !status_valid);
    cmd_valid <= 0;
    for (int n = 0; n < 2 && code[3:0] == 4'h4; n++) begin
      while (!sense_valid) @(posedge core_clk);
      sb[8*n +: 8] = sense_data;
      repeat (lag) @(posedge core_clk);
      sense_accept <= 1;
      @(posedge core_clk);
      sense_accept <= 0;
      @(posedge core_clk);
    end
    while (!status_valid) @(posedge core_clk);
    st = status_byte;
    repeat (lag) @(posedge core_clk);
    status_accept <= 1;
    @(posedge core_clk);
    status_accept <= 0;
    @(posedge core_clk);
  endtask
endmodule // crsm_host

// file: tb/card_reader_sense_motor_ctrl_tb.sv
module card_reader_sense_motor_ctrl_tb;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int SPIN = 50;
  localparam int IDLE = 200;
  logic core_clk, sys_rst, psel, penable, pwrite, ovr, er, mid;
  logic [11:0] paddr, amp;
  logic [31:0] pwdata, rd;
  logic [8:0] pin;
  logic [7:0] st;
  logic [15:0] sb;
  wire [31:0] prdata;
  wire pready, pslverr, cmd_valid, cmd_ack, status_valid, sense_valid;
  wire status_accept, sense_accept, motor_on, feed_coil, reader_busy;
  wire [7:0] cmd_code, status_byte, sense_data, panel_ind;
  int n_errors = 0;
  int cmp_count = 0;
  int k;
  crsm_top #(.SPIN_CYC(SPIN), .IDLE_CYC(IDLE), .GATE_CYC(30)) crsm_top_inst (.*,
    .overrun_det(ovr), .read_cells_pin(pin[0]), .gate_cell_pin(pin[1]),
    .card_path_pin(pin[2]), .interlock_pin(pin[3]), .stop_sw_pin(pin[4]),
    .run_sw_pin(pin[5]), .feed_sw_pin(pin[6]), .hopper_empty_pin(pin[7]),
    .col_strobe_pin(pin[8]), .mid_edge_pin(mid), .amp_pin(amp),
    .st2_pin(12'h000), .hole_edge_pin(1'b0), .hole_check_pin(1'b0), .panel_ind(panel_ind));
  crsm_host crsm_host_inst (.*);
  initial begin
    core_clk = 0;
    forever #20 core_clk = ~core_clk;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // one apb transfer, then one idle cycle
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    psel <= 1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1;
    do @(posedge core_clk); while (!pready);
    rd = prdata;
    er = pslverr;
    psel <= 0;
    penable <= 0;
    @(posedge core_clk);
  endtask
  task automatic close_out;
    $display("errors %0d compares %0d", n_errors, cmp_count);
    if (n_errors == 0 && cmp_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic t_boot;
    chk(motor_on, 0);
    apb(0, 12'h004, 0);
    chk(rd[6], 1);
  endtask
  task automatic t_regs;
    apb(1, 12'h000, 32'h0000_0003);
    apb(0, 12'h010, 0);
    chk(er, 1);
    crsm_host_inst.issue(8'h04, 0, st, sb);
    chk(sb[15:13], 3'b110);
    chk(st[6:5], 2'b01);
    apb(1, 12'h000, 32'h0000_0001);
    apb(0, 12'h004, 0);
    chk(rd[15:13], 3'b010);
  endtask
  task automatic t_cmds;
    logic [7:0] c[5] = '{8'h02, 8'h00, 8'h01, 8'h03, 8'hF1};
    for (int i = 0; i < 5; i++) begin
      crsm_host_inst.issue(c[i], i, st, sb);
      chk(st[6], 1);
      chk(motor_on, 0);
      crsm_host_inst.issue(8'h04, 4 - i, st, sb);
      chk(sb[0], i > 0);
      chk(sb[6], 1);
    end
  endtask
  task automatic t_flags;
    pin[7] <= 1;
    ovr <= 1;
    @(posedge core_clk);
    ovr <= 0;
    repeat (4) @(posedge core_clk);
    apb(0, 12'h004, 0);
    chk(rd[1], 1);
    chk(rd[5], 1);
    pin[7] <= 0;
  endtask
  task automatic t_feed;
    pin[5] <= 1;
    repeat (4) @(posedge core_clk);
    pin[5] <= 0;
    repeat (4) @(posedge core_clk);
    crsm_host_inst.issue(8'h04, 1, st, sb);
    crsm_host_inst.issue(8'h04, 0, st, sb);
    chk(sb[7:0], 8'h01);
    pin[6] <= 1;
    repeat (2) @(posedge core_clk);
    pin[6] <= 0;
    for (k = 0; k < 10 && !motor_on; k++) @(posedge core_clk);
    chk(motor_on, 1);
    for (k = 0; k < SPIN + 20 && !feed_coil; k++) @(posedge core_clk);
    chk(k >= SPIN - 4, 1);
    for (k = 0; k < IDLE + 20 && motor_on; k++) @(posedge core_clk);
    chk(k + SPIN > IDLE - 12 && k + SPIN < IDLE + 12, 1);
  endtask
  task automatic t_read;
    fork
      crsm_host_inst.issue(8'h02, 2, st, sb);
      begin
        repeat (4) @(posedge core_clk);
        chk(motor_on, 1);
        chk(reader_busy, 1);
        ovr <= 1;
        amp <= 12'h801;
        mid <= 1;
        @(posedge core_clk);
        ovr <= 0;
        repeat (3) @(posedge core_clk);
        mid <= 0;
        amp <= 12'h000;
        pin[0] <= 1;
        pin[2] <= 1;
        repeat (6) @(posedge core_clk);
        pin[0] <= 0;
        pin[2] <= 0;
      end
    join
    chk(st, 8'h60);
    apb(0, 12'h004, 0);
    chk(rd[8], 1);
    chk(rd[4], 1);
    chk(rd[0], 0);
  endtask
  task automatic t_intlk;
    pin[6] <= 1;
    repeat (8) @(posedge core_clk);
    pin[6] <= 0;
    pin[3] <= 1;
    repeat (6) @(posedge core_clk);
    chk(motor_on, 0);
    apb(0, 12'h004, 0);
    chk(rd[7:6], 2'b11);
    chk({panel_ind[7], panel_ind[2:1]}, 3'b110);
    pin[3] <= 0;
  endtask
  initial begin
    {psel, penable, pwrite, ovr, mid, amp, paddr, pwdata, pin} = 0;
    sys_rst = 1;
    repeat (5) @(posedge core_clk);
    sys_rst <= 0;
    @(posedge core_clk);
    t_boot();
    t_regs();
    t_cmds();
    t_feed();
    t_read();
    t_flags();
    t_intlk();
    close_out();
  end
  // hang guard
  initial begin
    repeat (20000) @(posedge core_clk);
    n_errors++;
    close_out();
  end
endmodule // card_reader_sense_motor_ctrl_tb
bind crsm_top crsm_top_chk #(.SPIN_CYC(SPIN_CYC), .IDLE_CYC(IDLE_CYC)) crsm_top_chk_inst (.*);
